// >>> verilog/eii_pkg.sv
// package of constants for the external input interlock block
// assumes one 25 MHz clock and raw terminal levels arriving from pins
//
// Operation
// - A wait command k from 2 to 15 halts sewing until the terminal for input k is active.
// - Wait commands 0 and 1 halt sewing the same way, released by functions 33 and 34.
// - While function 49 is active, presser switch 1 to 4 inputs are ignored.
// - While function 50 is active, start switch inputs are ignored.
// - Function 51 holds a requested sewing start until it drops, ignored once sewing runs.
// - Function 52 delays the xy drive start until it drops, ignored while xy already runs.
// - Function 53 withholds presser lowering and head start until it drops, not during driving.
// - Function 54 suspends operation after head stop and lifting complete until it drops.
// - Function 55 suspends feeding frame total lift and lower until it drops.
// - Function 55 never blocks frame motion commanded by the presser pedal.
`default_nettype none

package eii_pkg;

  // ==========================================================================
  // function numbers of the assignable terminals
  localparam int unsigned EII_FN_EXT0    = 33;
  localparam int unsigned EII_FN_LAST    = 55;
  localparam int unsigned EII_N_FN       = EII_FN_LAST - EII_FN_EXT0 + 1;
  localparam int unsigned EII_FN_PRESSER = 49;
  localparam int unsigned EII_FN_START   = 50;
  localparam int unsigned EII_FN_SEWWAIT = 51;
  localparam int unsigned EII_FN_XYWAIT  = 52;
  localparam int unsigned EII_FN_HDSTART = 53;
  localparam int unsigned EII_FN_HDSTOP  = 54;
  localparam int unsigned EII_FN_FRAME   = 55;

  // ==========================================================================
  // widths and reset values
  localparam int unsigned EII_N_EXT      = 16;
  localparam int unsigned EII_SYNC_STAGE = 2;
  localparam logic        EII_RST_LEVEL  = 1'b0;

  typedef enum logic [1:0] {
    EII_IDLE,
    EII_HOLD,
    EII_GO
  } eii_gate_type;

endpackage

`default_nettype wire

// >>> verilog/eii_gate.sv
// one hold-off gate: latches a request, waits while an inhibit is active
// assumes request and inhibit are already synchronous to i_mclk
`default_nettype none

module eii_gate
  import eii_pkg::*;
(
  input  wire logic i_mclk,
  input  wire logic i_rst_n,
  input  wire logic i_req,
  input  wire logic i_inhibit,
  input  wire logic i_busy,
  output logic      o_go,
  output logic      o_waiting
);

  eii_gate_type state_q;
  eii_gate_type state_d;
  logic         go_q;

  // ==========================================================================
  // next state
  // busy means the guarded motion already runs, so the inhibit is disregarded
  always_comb begin
    state_d = state_q;
    case (state_q)
      EII_IDLE: begin
        if (i_req && i_inhibit && !i_busy) begin
          state_d = EII_HOLD;
        end else if (i_req) begin
          state_d = EII_GO;
        end
      end
      EII_HOLD: begin
        if (!i_inhibit) begin
          state_d = EII_GO;
        end
      end
      EII_GO: begin
        state_d = EII_IDLE;
      end
      default: begin
        state_d = EII_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= EII_IDLE;
      go_q    <= EII_RST_LEVEL;
    end else begin
      state_q <= state_d;
      go_q    <= (state_d == EII_GO);
    end
  end

  assign o_go      = go_q;
  assign o_waiting = (state_q == EII_HOLD);

endmodule

`default_nettype wire

// >>> verilog/eii_top.sv
// external input interlock: pattern waits and operation hold-offs
// assumes terminal levels arrive asynchronously, active high after polarity fix
`default_nettype none

module eii_top
  import eii_pkg::*;
(
  input  wire logic                 i_mclk,
  input  wire logic                 i_rst_n,
  input  wire logic [EII_N_FN-1:0]  i_term,
  input  wire logic                 i_wait_cmd,
  input  wire logic [3:0]           i_wait_num,
  input  wire logic                 i_sewing,
  input  wire logic [3:0]           i_presser_sw,
  input  wire logic                 i_start_sw,
  input  wire logic                 i_xy_req,
  input  wire logic                 i_xy_running,
  input  wire logic                 i_head_req,
  input  wire logic                 i_upper_reset,
  input  wire logic                 i_head_driving,
  input  wire logic                 i_head_stop_done,
  input  wire logic                 i_frame_req,
  input  wire logic                 i_frame_pedal,
  output logic                      o_sew_halt,
  output logic [3:0]                o_presser_sw,
  output logic                      o_start_sw,
  output logic                      o_sew_start,
  output logic                      o_xy_start,
  output logic                      o_head_start,
  output logic                      o_stop_hold,
  output logic                      o_frame_go
);

  // ==========================================================================
  // synchronisers
  logic [EII_N_FN-1:0] meta_q;
  logic [EII_N_FN-1:0] term_q;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= '0;
      term_q <= '0;
    end else begin
      meta_q <= i_term;
      term_q <= meta_q;
    end
  end

  function automatic logic fn_on(input logic [EII_N_FN-1:0] t, input int unsigned fn);
    fn_on = t[fn - EII_FN_EXT0];
  endfunction

  wire logic [EII_N_EXT-1:0] ext_lvl = term_q[EII_N_EXT-1:0];
  wire logic inh_presser = fn_on(term_q, EII_FN_PRESSER);
  wire logic inh_start   = fn_on(term_q, EII_FN_START);
  wire logic inh_sew     = fn_on(term_q, EII_FN_SEWWAIT);
  wire logic inh_xy      = fn_on(term_q, EII_FN_XYWAIT);
  wire logic inh_hstart  = fn_on(term_q, EII_FN_HDSTART);
  wire logic inh_hstop   = fn_on(term_q, EII_FN_HDSTOP);
  wire logic inh_frame   = fn_on(term_q, EII_FN_FRAME);

  // ==========================================================================
  // pattern wait commands
  logic       wait_q;
  logic [3:0] wnum_q;

  wire logic wait_rel = ext_lvl[wnum_q];
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wait_q <= 1'b0;
      wnum_q <= 4'h0;
    end else if (i_wait_cmd) begin
      wait_q <= 1'b1;
      wnum_q <= i_wait_num;
    end else if (wait_q && wait_rel) begin
      wait_q <= 1'b0;
    end
  end

  // ==========================================================================
  // switch prohibits
  logic [3:0] psw_q;
  logic       ssw_q;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      psw_q <= 4'h0;
      ssw_q <= 1'b0;
    end else begin
      psw_q <= inh_presser ? 4'h0 : i_presser_sw;
      ssw_q <= i_start_sw & ~inh_start;
    end
  end

  // ==========================================================================
  // hold-off gates
  wire logic start_ok = i_start_sw & ~inh_start;
  wire logic hd_busy  = i_head_driving | i_upper_reset;
  wire logic frame_go;
  wire logic pedal_go = i_frame_req & i_frame_pedal;
  logic      frame_q;
  logic      hstop_q;

  eii_gate u_sew (
    .i_mclk    (i_mclk),
    .i_rst_n   (i_rst_n),
    .i_req     (start_ok),
    .i_inhibit (inh_sew),
    .i_busy    (i_sewing),
    .o_go      (o_sew_start),
    .o_waiting ()
  );

  eii_gate u_xy (
    .i_mclk    (i_mclk),
    .i_rst_n   (i_rst_n),
    .i_req     (i_xy_req),
    .i_inhibit (inh_xy),
    .i_busy    (i_xy_running),
    .o_go      (o_xy_start),
    .o_waiting ()
  );

  eii_gate u_head (
    .i_mclk    (i_mclk),
    .i_rst_n   (i_rst_n),
    .i_req     (i_head_req),
    .i_inhibit (inh_hstart),
    .i_busy    (hd_busy),
    .o_go      (o_head_start),
    .o_waiting ()
  );

  eii_gate u_frame (
    .i_mclk    (i_mclk),
    .i_rst_n   (i_rst_n),
    .i_req     (i_frame_req & ~i_frame_pedal),
    .i_inhibit (inh_frame),
    .i_busy    (1'b0),
    .o_go      (frame_go),
    .o_waiting ()
  );

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      frame_q <= 1'b0;
      hstop_q <= 1'b0;
    end else begin
      frame_q <= frame_go | pedal_go;
      hstop_q <= inh_hstop & ~hd_busy & (i_head_stop_done | hstop_q);
    end
  end

  assign o_sew_halt   = wait_q;
  assign o_presser_sw = psw_q;
  assign o_start_sw   = ssw_q;
  assign o_stop_hold  = hstop_q;
  assign o_frame_go   = frame_q;

endmodule

`default_nettype wire

// >>> dv/eii_seq_model.sv
// sequencer model: drives terminal levels off the falling clock edge
// assumes the bench sets wanted levels at the rising edge
`default_nettype none
module eii_seq_model
  import eii_pkg::*;
(
  input  wire logic                i_mclk,
  input  wire logic [EII_N_FN-1:0] i_want,
  output logic      [EII_N_FN-1:0] o_term
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // terminal drive
  // falling edge keeps levels unrelated to sampling
  always @(negedge i_mclk) begin
    o_term <= i_want;
  end
endmodule
`default_nettype wire

// >>> dv/eii_properties.sv
// checker on eii_top ports: masks, hold-offs, pedal bypass
// assumes one clock and quiet motion status during checks
`default_nettype none
module eii_properties
  import eii_pkg::*;
(
  input wire logic                i_mclk,
  input wire logic                i_rst_n,
  input wire logic [EII_N_FN-1:0] i_term,
  input wire logic [3:0]          i_presser_sw,
  input wire logic                i_sewing,
  input wire logic                o_sew_start,
  input wire logic                i_xy_req,
  input wire logic                i_xy_running,
  input wire logic                i_head_driving,
  input wire logic                i_upper_reset,
  input wire logic                i_frame_req,
  input wire logic                i_frame_pedal,
  input wire logic [3:0]          o_presser_sw,
  input wire logic                o_start_sw,
  input wire logic                o_xy_start,
  input wire logic                o_head_start,
  input wire logic                o_frame_go
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  // ==========================================
  // masks and gates
  sequence xy_free;
    (!i_term[19])[*5] ##0 i_xy_req;
  endsequence
  presser_mask_a: assert property (i_term[16][*5] |-> o_presser_sw == 4'h0)
    else $error("presser switches not masked");
  presser_pass_a: assert property ((!i_term[16])[*5] |-> o_presser_sw == $past(i_presser_sw))
    else $error("presser switches not passed");
  start_mask_a: assert property (i_term[17][*5] |-> !o_start_sw)
    else $error("start switch not masked");
  sew_hold_a: assert property ((i_term[18] && !i_sewing)[*6] |-> !o_sew_start)
    else $error("sewing start while inhibited");
  xy_hold_a: assert property ((i_term[19] && !i_xy_running)[*6] |-> !o_xy_start)
    else $error("xy start while inhibited");
  xy_go_a: assert property (xy_free |-> ##1 o_xy_start)
    else $error("xy start missing");
  head_hold_a: assert property ((i_term[20] && !i_head_driving && !i_upper_reset)[*6] |-> !o_head_start)
    else $error("head start while inhibited");
  frame_hold_a: assert property ((i_term[22] && !i_frame_pedal)[*6] |-> !o_frame_go)
    else $error("frame motion while inhibited");
  pedal_pass_a: assert property (i_frame_req && i_frame_pedal |=> o_frame_go)
    else $error("pedal frame motion blocked");
endmodule
bind eii_top eii_properties u_eii_properties (.*);
`default_nettype wire

// >>> dv/tb.sv
// bench for eii_top: waits, switch masks and hold-off gates
// assumes the sequencer model owns the terminal pins
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import eii_pkg::*;
  logic                i_mclk  = 1'b0;
  logic                i_rst_n = 1'b0;
  logic [EII_N_FN-1:0] want    = '0;
  logic                wc      = 1'b0;
  logic [3:0]          wn      = 4'h0;
  logic [3:0]          psw     = 4'h0;
  logic                ssw     = 1'b0;
  logic [2:0]          rq      = 3'h0;
  logic                hsd     = 1'b0;
  logic                ped     = 1'b0;
  wire  [EII_N_FN-1:0] term;
  wire                 halt, st_o, hold;
  wire  [3:0]          psw_o;
  wire  [3:0]          go;
  wire  [5:0]          ev = {!hold, !halt, go};
  int                  n_fail = 0;
  int                  checks = 0;
  int                  tbit[3] = '{19, 20, 22};
  always #20 i_mclk = ~i_mclk;
  eii_seq_model u_eii_seq_model (.i_mclk(i_mclk), .i_want(want), .o_term(term));
  // motion status tied quiet: busy bypass left unexercised
  eii_top u_eii_top (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_term(term), .i_wait_cmd(wc),
    .i_wait_num(wn), .i_sewing(1'b0), .i_presser_sw(psw), .i_start_sw(ssw), .i_xy_req(rq[0]),
    .i_xy_running(1'b0), .i_head_req(rq[1]), .i_upper_reset(1'b0), .i_head_driving(1'b0),
    .i_head_stop_done(hsd), .i_frame_req(rq[2]), .i_frame_pedal(ped), .o_sew_halt(halt),
    .o_presser_sw(psw_o), .o_start_sw(st_o), .o_sew_start(go[3]), .o_xy_start(go[0]),
    .o_head_start(go[1]), .o_stop_hold(hold), .o_frame_go(go[2]));
  // ==========================================
  // shared tasks
  task automatic final_report();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic await(input int e);
    for (int i = 0; i < 20; i++) begin
      #1;
      if (ev[e] === 1'b1) begin
        checks++;
        return;
      end
      @(posedge i_mclk);
    end
    n_fail++;
    final_report();
  endtask
  // ==========================================
  // scenarios
  task automatic t_wait(input logic [3:0] k);
    @(posedge i_mclk) {wc, wn} <= {1'b1, k};
    @(posedge i_mclk) wc <= 1'b0;
    repeat (4) @(posedge i_mclk);
    #1 chk({3'h0, halt}, 4'h1);
    @(posedge i_mclk) want[k] <= 1'b1;
    await(4);
    @(posedge i_mclk) want[k] <= 1'b0;
  endtask
  task automatic t_mask();
    @(posedge i_mclk) {want[17:16], psw, ssw} <= {2'h3, 4'hf, 1'b1};
    repeat (6) @(posedge i_mclk);
    #1 chk(psw_o, 4'h0);
    chk({3'h0, st_o}, 4'h0);
    @(posedge i_mclk) want[17:16] <= 2'h0;
    repeat (6) @(posedge i_mclk);
    #1 chk(psw_o, 4'hf);
    chk({3'h0, st_o}, 4'h1);
    @(posedge i_mclk) {psw, ssw} <= 5'h00;
  endtask
  task automatic t_hold(input int g);
    @(posedge i_mclk) want[tbit[g]] <= 1'b1;
    repeat (4) @(posedge i_mclk);
    rq[g] <= 1'b1;
    @(posedge i_mclk) rq[g] <= 1'b0;
    repeat (8) @(posedge i_mclk);
    #1 chk(go, 4'h0);
    @(posedge i_mclk) want[tbit[g]] <= 1'b0;
    await(g);
    repeat (6) @(posedge i_mclk);
    rq[g] <= 1'b1;
    @(posedge i_mclk) rq[g] <= 1'b0;
    await(g);
  endtask
  task automatic t_sew();
    @(posedge i_mclk) want[18] <= 1'b1;
    repeat (4) @(posedge i_mclk);
    ssw <= 1'b1;
    @(posedge i_mclk) ssw <= 1'b0;
    repeat (8) @(posedge i_mclk);
    #1 chk(go, 4'h0);
    @(posedge i_mclk) want[18] <= 1'b0;
    await(3);
  endtask
  task automatic t_pedal();
    @(posedge i_mclk) want[22] <= 1'b1;
    repeat (4) @(posedge i_mclk);
    {ped, rq[2]} <= 2'h3;
    @(posedge i_mclk) rq[2] <= 1'b0;
    await(2);
    @(posedge i_mclk) {ped, want[22]} <= 2'h0;
  endtask
  task automatic t_stop();
    @(posedge i_mclk) want[21] <= 1'b1;
    repeat (4) @(posedge i_mclk);
    hsd <= 1'b1;
    @(posedge i_mclk) hsd <= 1'b0;
    repeat (3) @(posedge i_mclk);
    #1 chk({3'h0, hold}, 4'h1);
    @(posedge i_mclk) want[21] <= 1'b0;
    await(5);
  endtask
  initial begin
    repeat (4) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    repeat (2) @(posedge i_mclk);
    t_wait(4'h0);
    t_wait(4'h1);
    t_wait(4'h2);
    t_wait(4'hf);
    t_mask();
    t_sew();
    t_hold(0);
    t_hold(1);
    t_hold(2);
    t_pedal();
    t_stop();
    final_report();
  end
endmodule
`default_nettype wire
